//--- core/dcec_top.v
// Event control of one DMA channel: start and abort triggers from IRQs
`timescale 1ns/100ps
`include "dcec_defs.vh"

module dcec_top (
   // Clock, reset and the register port
   input  wire         i_clk,
   input  wire         i_rstn,
   input  wire [3:0]   i_addr,
   input  wire [31:0]  i_wdata,
   input  wire         i_wr,
   input  wire         i_rd,
   output reg  [31:0]  o_rdata,
   // Request lines, asynchronous to this clock
   input  wire [255:0] i_irq,
   input  wire         i_pattern_match,
   // Commands to the channel transfer engine, and the interrupt output
   output wire         o_start,
   output wire         o_abort,
   output wire         o_set_channel_abort_flag,
   output wire         o_clear_channel_enable_bit,
   output wire         o_irq
);

   reg  [255:0] irq_meta;
   reg  [255:0] irq_sync;
   reg  [255:0] irq_prev;
   reg          pat_meta;
   reg          pat_sync;
   reg  [7:0]   abort_irq_select;
   reg  [7:0]   start_irq_select;
   reg          pattern_abort_enable;
   reg          start_irq_enable;
   reg          abort_irq_enable;
   reg  [`DCEC_EV_WIDTH-1:0] ev_status;
   reg  [`DCEC_EV_WIDTH-1:0] ev_mask;
   reg  [31:0]  next_rdata;

   wire [255:0] irq_rise;
   wire         wr_econ;
   wire         wr_mask;
   wire         force_transfer_strobe;
   wire         abort_transfer_strobe;
   wire         start_irq_hit;
   wire         abort_irq_hit;
   wire         pattern_hit;
   wire         rd_status;
   wire [`DCEC_EV_WIDTH-1:0] events;
   wire [`DCEC_EV_WIDTH-1:0] next_status;

   // Any of the 256 numbers is a legal selector, so no range check
   function sel_hit;
      input [255:0] vec;
      input [7:0]   sel;
      begin
         sel_hit = vec[sel];
      end
   endfunction

   // Strobe qualified by one register offset; shared by the write and status-read decoders
   function reg_hit;
      input       strobe;
      input [3:0] addr;
      input [3:0] offset;
      begin
         reg_hit = strobe && (addr == offset);
      end
   endfunction

   // Request lines come from other logic: two flops against metastability
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_meta <= 256'h0;
         irq_sync <= 256'h0;
         irq_prev <= 256'h0;
      end else begin
         irq_meta <= i_irq;
         irq_sync <= irq_meta;
         irq_prev <= irq_sync;
      end
   end

   // The match level takes the same two stages as the requests, so a
   // pattern abort never overtakes an abort request raised beside it
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pat_meta <= 1'b0;
         pat_sync <= 1'b0;
      end else begin
         pat_meta <= i_pattern_match;
         pat_sync <= pat_meta;
      end
   end

   // A request held high by a slow source still gives a single event
   assign irq_rise = irq_sync & ~irq_prev;

   assign wr_econ = reg_hit(i_wr, i_addr, `DCEC_OFF_ECON);
   assign wr_mask = reg_hit(i_wr, i_addr, `DCEC_OFF_MASK);
   assign force_transfer_strobe = wr_econ &&
                                  i_wdata[`DCEC_FORCE_BIT];
   assign abort_transfer_strobe = wr_econ &&
                                  i_wdata[`DCEC_ABORT_BIT];

   assign start_irq_hit = start_irq_enable &&
      sel_hit(irq_rise, start_irq_select);
   assign abort_irq_hit = abort_irq_enable &&
      sel_hit(irq_rise, abort_irq_select);
   // Pattern abort is a level: repeated aborts while matching are harmless
   assign pattern_hit = pattern_abort_enable && pat_sync;

   // Abort wins over start when both land in one cycle
   assign o_abort = abort_irq_hit ||
                    abort_transfer_strobe ||
                    pattern_hit;
   // A force write is counted in the status like a start request
   assign o_start = (start_irq_hit || force_transfer_strobe) &&
                    !o_abort;
   assign o_set_channel_abort_flag = abort_irq_hit;
   assign o_clear_channel_enable_bit = pattern_hit;

   // Selectors leave reset pointing at the highest request number
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         abort_irq_select <= `DCEC_SEL_RESET;
         start_irq_select <= `DCEC_SEL_RESET;
      end else if (wr_econ) begin
         abort_irq_select <=
            i_wdata[`DCEC_ABORT_SEL_HI:`DCEC_ABORT_SEL_LO];
         start_irq_select <=
            i_wdata[`DCEC_START_SEL_HI:`DCEC_START_SEL_LO];
      end
   end

   // No byte lanes: every write rewrites all fields, so software must
   // write the selectors back together with the enables
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pattern_abort_enable <= `DCEC_EN_RESET;
         start_irq_enable     <= `DCEC_EN_RESET;
         abort_irq_enable     <= `DCEC_EN_RESET;
      end else if (wr_econ) begin
         pattern_abort_enable <= i_wdata[`DCEC_PAT_EN_BIT];
         start_irq_enable     <= i_wdata[`DCEC_START_EN_BIT];
         abort_irq_enable     <= i_wdata[`DCEC_ABORT_EN_BIT];
      end
   end

   // Status layout: start, abort, pattern abort
   assign events[`DCEC_EV_START]   = o_start;
   assign events[`DCEC_EV_ABORT]   = o_abort;
   assign events[`DCEC_EV_PATTERN] = pattern_hit;
   assign rd_status = reg_hit(i_rd, i_addr, `DCEC_OFF_STATUS);

   // One sticky bit per event; an event in the clearing read's cycle
   // survives the clear, so nothing is lost between read and clear
   genvar g;
   generate
      for (g = 0; g < `DCEC_EV_WIDTH; g = g + 1) begin : g_sticky
         assign next_status[g] = events[g] |
                                 (ev_status[g] & ~rd_status);
      end
   endgenerate

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ev_status <= {`DCEC_EV_WIDTH{1'b0}};
         ev_mask   <= `DCEC_MASK_RESET;
      end else begin
         ev_status <= next_status;
         if (wr_mask) begin
            ev_mask <= i_wdata[`DCEC_EV_WIDTH-1:0];
         end
      end
   end

   // Level output: stays high until a status read or the mask drops it
   assign o_irq = |(ev_status & ev_mask);

   // Strobe and unimplemented bits are never stored, so they read zero
   always @* begin
      next_rdata = 32'h0;
      if (i_rd) begin
         case (i_addr)
            `DCEC_OFF_ECON: begin
               next_rdata = {8'h00, abort_irq_select,
                             start_irq_select, 2'h0,
                             pattern_abort_enable, start_irq_enable,
                             abort_irq_enable, 3'h0};
            end
            `DCEC_OFF_STATUS: begin
               next_rdata = {29'h0, ev_status};
            end
            `DCEC_OFF_MASK: begin
               next_rdata = {29'h0, ev_mask};
            end
            default: begin
               next_rdata = 32'h0;
            end
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe, zero otherwise
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

endmodule // dcec_top

//--- core/dcec_defs.vh
// Register map, field positions and reset values of the DMA event control
`ifndef DCEC_DEFS_VH
`define DCEC_DEFS_VH

`define DCEC_OFF_ECON     4'h0
`define DCEC_OFF_STATUS   4'h4
`define DCEC_OFF_MASK     4'h8

`define DCEC_ABORT_SEL_HI 23
`define DCEC_ABORT_SEL_LO 16
`define DCEC_START_SEL_HI 15
`define DCEC_START_SEL_LO 8
`define DCEC_FORCE_BIT    7
`define DCEC_ABORT_BIT    6
`define DCEC_PAT_EN_BIT   5
`define DCEC_START_EN_BIT 4
`define DCEC_ABORT_EN_BIT 3

`define DCEC_SEL_RESET    8'hFF
`define DCEC_EN_RESET     1'h0
`define DCEC_MASK_RESET   3'h0

`define DCEC_EV_START     0
`define DCEC_EV_ABORT     1
`define DCEC_EV_PATTERN   2
`define DCEC_EV_WIDTH     3

`endif

//--- sim/dcec_assertions.sv
// Checker of dcec_top port timing
`timescale 1ns/100ps
module dcec_checker(
   input wire logic i_clk,i_rstn,i_wr,i_rd,i_pattern_match,o_start,o_abort,
   input wire logic o_set_channel_abort_flag,o_clear_channel_enable_bit,o_irq,
   input wire logic [3:0]   i_addr,
   input wire logic [31:0]  i_wdata,o_rdata,
   input wire logic [255:0] i_irq);
default clocking @(posedge i_clk);endclocking
default disable iff(!i_rstn);
wire ew=i_wr&&i_addr==4'h0;
wire anyirq=|i_irq;
sequence s_one;o_set_channel_abort_flag##1!o_set_channel_abort_flag;endsequence
property p_rsv;$past(i_rd)&&$past(i_addr)==4'h0
   |->(o_rdata&32'hFF0000C7)==32'h0;endproperty
a_rsv:assert property(p_rsv)else $error("reserved");
property p_frc;ew&&i_wdata[7]&&!o_abort|->o_start;endproperty
a_frc:assert property(p_frc)else $error("force");
property p_abw;ew&&i_wdata[6]|->o_abort;endproperty
a_abw:assert property(p_abw)else $error("abort");
property p_flg;o_set_channel_abort_flag|->o_abort;endproperty
a_flg:assert property(p_flg)else $error("flag");
property p_flp;o_set_channel_abort_flag|->s_one;endproperty
a_flp:assert property(p_flp)else $error("pulse");
property p_clr;o_clear_channel_enable_bit|->o_abort;endproperty
a_clr:assert property(p_clr)else $error("clear");
// A start with no write behind it must come from a request two or three
// edges back, through the synchroniser
property p_src;o_start&&!ew|->$past(anyirq,2)||$past(anyirq,3);endproperty
a_src:assert property(p_src)else $error("start");
property p_pcs;o_clear_channel_enable_bit
   |->$past(i_pattern_match,2)||$past(i_pattern_match,3);endproperty
a_pcs:assert property(p_pcs)else $error("match");
endmodule // dcec_checker
bind dcec_top dcec_checker u_chk(.i_clk(i_clk),.i_rstn(i_rstn),.i_wr(i_wr),
   .i_rd(i_rd),.i_pattern_match(i_pattern_match),.o_start(o_start),
   .o_abort(o_abort),.o_set_channel_abort_flag(o_set_channel_abort_flag),
   .o_clear_channel_enable_bit(o_clear_channel_enable_bit),.o_irq(o_irq),
   .i_addr(i_addr),.i_wdata(i_wdata),.o_rdata(o_rdata),.i_irq(i_irq));

//--- sim/dcec_partner.sv
// Interrupt source model raising one request line on demand
`timescale 1ns/100ps
module dcec_partner(
   input  wire logic         i_clk,
   input  wire logic [7:0]   i_num,
   input  wire logic         i_fire,
   output logic      [255:0] o_irq);
// A held request stays a level, so the block sees one edge only
always @(posedge i_clk) o_irq<=i_fire?256'h1<<i_num:256'h0;
endmodule // dcec_partner

//--- sim/tb_dma_channel_event_control.sv
// Directed bench: registers, trigger events and interrupt flow
`timescale 1ns/100ps
module tb_dma_channel_event_control;
logic clk=0,rstn=0,wr=0,rd=0,fire=0,pat=0,st,ab,fl,cl,oi;
logic [3:0] a=4'h0;
logic [7:0] num=8'h0;
logic [31:0] wd=32'h0,rdat;
logic [255:0] irq;
int n_errors=0,n_checks=0,ns=0,na=0,nf=0,nc=0;
always #2 clk=~clk;
dcec_partner u_p(.i_clk(clk),.i_num(num),.i_fire(fire),.o_irq(irq));
dcec_top u_dut(.i_clk(clk),.i_rstn(rstn),.i_addr(a),.i_wdata(wd),
   .i_wr(wr),.i_rd(rd),.o_rdata(rdat),.i_irq(irq),.i_pattern_match(pat),
   .o_start(st),.o_abort(ab),.o_set_channel_abort_flag(fl),
   .o_clear_channel_enable_bit(cl),.o_irq(oi));
always @(posedge clk) begin
   ns+=st;na+=ab;nf+=fl;nc+=cl;
end
task chk(input string s,input logic [31:0] e,g);
   n_checks++;
   if(e!==g) begin
      n_errors++;
      $display("Error %s expected %h seen %h",s,e,g);
   end
endtask
task wr1(input logic [3:0] ad,input logic [31:0] d);
   @(posedge clk) begin a<=ad;wd<=d;wr<=1'b1;end
   @(posedge clk) wr<=1'b0;
endtask
task rd1(input logic [3:0] ad,input logic [31:0] e,input string s);
   @(posedge clk) begin a<=ad;rd<=1'b1;end
   @(posedge clk) rd<=1'b0;
   #1 chk(s,e,rdat);
endtask
task clr;
   #1 ns=0;na=0;nf=0;nc=0;
endtask
// Request held for eight cycles, so a level-sensitive block would repeat
task ev(input logic [7:0] n);
   @(posedge clk) begin num<=n;fire<=1'b1;end
   repeat(8) @(posedge clk);
   fire<=1'b0;
   repeat(4) @(posedge clk);
   #1;
endtask
task wrap_up;
   $display("errors %0d checks %0d",n_errors,n_checks);
   if(n_errors==0&&n_checks>0) $display("Result: passed");
   else $display("Result: failed");
   $finish;
endtask
initial begin
   #40000 n_errors++;
   wrap_up;
end
initial begin
   repeat(12) @(posedge clk);
   rstn<=1'b1;
   rd1(4'h0,32'h00FFFF00,"econ");
   wr1(4'h8,32'h7);
   wr1(4'h0,32'hFFFFFFFF);
   rd1(4'h0,32'h00FFFF38,"econ");
   rd1(4'hC,32'h0,"unmapped");
   wr1(4'h0,32'h00090518);
   clr;
   ev(8'h05);
   chk("start",32'h1,ns);
   ev(8'h09);
   chk("abort",32'h1,na);
   chk("flag",32'h1,nf);
   wr1(4'h0,32'h00090500);
   clr;
   ev(8'h05);
   ev(8'h09);
   chk("ignored",32'h0,ns+na);
   clr;
   wr1(4'h0,32'h80);
   #1 chk("force",32'h1,ns);
   clr;
   wr1(4'h0,32'h40);
   #1 chk("kill",32'h1,na);
   rd1(4'h0,32'h0,"strobes");
   clr;
   wr1(4'h0,32'h20);
   pat<=1'b1;
   repeat(5) @(posedge clk);
   pat<=1'b0;
   repeat(4) @(posedge clk);
   #1 chk("pattern",32'h5,nc);
   chk("pattern abort",32'h5,na);
   chk("irq",32'h1,oi);
   rd1(4'h4,32'h7,"status");
   chk("irq",32'h0,oi);
   wr1(4'h8,32'h0);
   wr1(4'h0,32'h80);
   #1 chk("masked",32'h0,oi);
   wr1(4'h8,32'h1);
   #1 chk("unmasked",32'h1,oi);
   @(posedge clk) rstn<=1'b0;
   repeat(2) @(posedge clk);
   rstn<=1'b1;
   rd1(4'h0,32'h00FFFF00,"econ after reset");
   wrap_up;
end
endmodule // tb_dma_channel_event_control
